//--- hw/kie_key_chan.sv
/*
 * kie_key_chan: one key input channel. Two-stage synchroniser, active level
 * by the selected polarity, and a valid-edge pulse that also fires when the
 * channel is enabled while the pin already sits at its active level.
 * Assumes the pin is asynchronous to i_mclk.
 */
`timescale 1ns/1ps
module kie_key_chan
(
    input  wire logic i_mclk,    // block clock
    input  wire logic i_resetn,  // async reset, active low
    input  wire logic i_ce,      // clock enable
    input  wire logic i_pin,     // raw key pin
    input  wire logic i_pol,     // 1 rising, 0 falling
    input  wire logic i_en,      // channel detect enable
    output logic      o_level,   // pin at active level
    output logic      o_edge     // valid edge pulse
);

    logic sync1_ff;
    logic sync2_ff;
    logic lvl_prev_ff;
    logic en_prev_ff;

    // ************************************************************
    // synchroniser and history
    // ************************************************************
    // sync1_ff feeds sync2_ff only, to keep metastability out of the logic
    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            sync1_ff    <= 1'b0;
            sync2_ff    <= 1'b0;
            lvl_prev_ff <= 1'b0;
            en_prev_ff  <= 1'b0;
        end
        else if (i_ce)
        begin
            sync1_ff    <= i_pin;
            sync2_ff    <= sync1_ff;
            lvl_prev_ff <= o_level;
            en_prev_ff  <= i_en;
        end
    end

    // polarity applies to all channels; flipping it can look like an edge
    assign o_level = i_pol ? sync2_ff : ~sync2_ff;
    // enabling over an active pin counts as an edge
    assign o_edge  = o_level & i_en & ~(lvl_prev_ff & en_prev_ff);

endmodule

//--- hw/kie_key_irq.sv
/*
 * kie_key_irq: eight-channel key input edge interrupt with an AHB-Lite
 * register slave, per-channel event flags and a maskable interrupt output.
 * Assumes one AHB-Lite master whose hready is this slave's o_hreadyout,
 * and key pins that may change at any time.
 */
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
module kie_key_irq
    import kie_pkg::*;
(
    input  wire logic              i_mclk,            // block clock, 100 MHz
    input  wire logic              i_resetn,          // async reset, active low
    input  wire logic              i_ce,              // clock enable, freezes all
    input  wire kie_ahb_req_s      i_ahb,             // AHB-Lite address phase
    input  wire logic [31:0]       i_hwdata,          // AHB-Lite write data
    output logic [31:0]            o_hrdata,          // AHB-Lite read data
    output logic                   o_hreadyout,       // AHB-Lite ready out
    output logic                   o_hresp,           // AHB-Lite response
    input  wire logic [KIE_NCH-1:0] i_key_input_pins, // key pins
    output logic                   o_key_irq,         // key request line
    output logic                   o_irq              // masked interrupt
);

    kie_bus_e           bus_st_ff;
    kie_bus_e           nxt_bus_st;
    logic [31:0]        addr_ff;
    logic [31:0]        hrdata_ff;
    kie_ctrl_s          ctrl_ff;
    logic [KIE_NCH-1:0] en_ff;
    logic [KIE_NCH-1:0] flags_ff;
    logic [KIE_NCH-1:0] nxt_flags;
    logic [KIE_NCH-1:0] pending_ff;
    logic [KIE_NCH-1:0] nxt_pending;
    logic               key_irq_ff;
    logic               nxt_key_irq;
    logic               status_ff;
    logic               nxt_status;
    logic               mask_ff;
    logic [KIE_NCH-1:0] lvl_all;
    logic [KIE_NCH-1:0] ev_all;

    // ************************************************************
    // bus decode
    // ************************************************************
    wire        take       = i_ahb.hsel & i_ahb.hready & i_ahb.htrans[KIE_HTRANS_ACT_BIT]
                             & (bus_st_ff != KIE_BUS_RDCAP);
    wire        wr_en      = (bus_st_ff == KIE_BUS_WRITE) & i_ce;
    wire        sel_ctrl   = (addr_ff == KIE_ADDR_CTRL);
    wire        sel_flags  = (addr_ff == KIE_ADDR_FLAGS);
    wire        sel_enable = (addr_ff == KIE_ADDR_ENABLE);
    wire        sel_status = (addr_ff == KIE_ADDR_STATUS);
    wire        sel_mask   = (addr_ff == KIE_ADDR_MASK);
    wire [7:0]  wdata_lo   = i_hwdata[7:0];
    wire        wr_flags   = wr_en & sel_flags;

    // read mux; unmapped addresses read as zero
    wire [7:0]  ctrl_byte  = {ctrl_ff.flag_mode_select, 6'h00,
                              ctrl_ff.edge_polarity_select};
    wire [7:0]  rd_byte    = sel_ctrl   ? ctrl_byte :
                             sel_flags  ? flags_ff :
                             sel_enable ? en_ff :
                             sel_status ? {7'h00, status_ff} :
                             sel_mask   ? {7'h00, mask_ff} : KIE_RST_BYTE;

    // reads take one wait state so a write just before is always seen
    assign o_hreadyout = i_ce & (bus_st_ff != KIE_BUS_RDCAP);
    assign o_hresp     = 1'b0;
    assign o_hrdata    = hrdata_ff;

    // ************************************************************
    // bus state machine
    // ************************************************************
    // next state from the transfer taken this cycle
    always_comb
    begin
        nxt_bus_st = bus_st_ff;
        case (bus_st_ff)
            KIE_BUS_IDLE,
            KIE_BUS_WRITE,
            KIE_BUS_RDOUT:
            begin
                if (take)
                    nxt_bus_st = i_ahb.hwrite ? KIE_BUS_WRITE : KIE_BUS_RDCAP;
                else
                    nxt_bus_st = KIE_BUS_IDLE;
            end
            KIE_BUS_RDCAP:
                nxt_bus_st = KIE_BUS_RDOUT;
            default:
                nxt_bus_st = KIE_BUS_IDLE;
        endcase
    end

    // state, captured address and read data
    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            bus_st_ff <= KIE_BUS_IDLE;
            addr_ff   <= 32'h0000_0000;
            hrdata_ff <= 32'h0000_0000;
        end
        else if (i_ce)
        begin
            bus_st_ff <= nxt_bus_st;
            if (take)
                addr_ff <= i_ahb.haddr;
            if (bus_st_ff == KIE_BUS_RDCAP)
                hrdata_ff <= {24'h00_0000, rd_byte};
        end
    end

    // ************************************************************
    // control and enable registers
    // ************************************************************
    // byte write carries every bit; a bit write is a read-modify-write byte
    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            ctrl_ff <= '0;
            en_ff   <= KIE_RST_BYTE;
            mask_ff <= 1'b0;
        end
        else if (wr_en)
        begin
            if (sel_ctrl)
            begin
                ctrl_ff.flag_mode_select     <= wdata_lo[KIE_CTRL_MODE_BIT];
                ctrl_ff.edge_polarity_select <= wdata_lo[KIE_CTRL_POL_BIT];
            end
            if (sel_enable)
                en_ff <= wdata_lo;
            if (sel_mask)
                mask_ff <= wdata_lo[KIE_STAT_KEY_BIT];
        end
    end

    // ************************************************************
    // key channels
    // ************************************************************
    // one synchroniser and edge detector per pin
    generate
        for (genvar ch = 0; ch < KIE_NCH; ch++)
        begin : g_chan
            kie_key_chan u_chan
            (
                .i_mclk   (i_mclk),
                .i_resetn (i_resetn),
                .i_ce     (i_ce),
                .i_pin    (i_key_input_pins[ch]),
                .i_pol    (ctrl_ff.edge_polarity_select),
                .i_en     (en_ff[ch]),
                .o_level  (lvl_all[ch]),
                .o_edge   (ev_all[ch])
            );
        end
    endgenerate

    // ************************************************************
    // event flags and key request
    // ************************************************************
    wire                mode        = ctrl_ff.flag_mode_select;
    wire                lvl_hit     = |(lvl_all & en_ff);
    wire                flags_busy  = |flags_ff;
    // zeros clear, ones leave the flag alone
    wire [KIE_NCH-1:0]  flag_keep   = wr_flags ? wdata_lo : KIE_ALL_ONES;
    wire [KIE_NCH-1:0]  kept_flags  = flags_ff & flag_keep;

    // while any flag stands, new edges wait so they raise one fresh request of their own once the flags clear;
    // an edge in the clearing cycle lands in pending, so set wins over clear
    assign nxt_flags   = !mode      ? KIE_RST_BYTE :
                         flags_busy ? kept_flags : (pending_ff | ev_all);
    assign nxt_pending = !mode      ? KIE_RST_BYTE :
                         flags_busy ? (pending_ff | ev_all) : KIE_RST_BYTE;
    // mode 0 tracks the combined pin level, mode 1 the flags
    assign nxt_key_irq = mode ? |nxt_flags : lvl_hit;

    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            flags_ff   <= KIE_RST_BYTE;
            pending_ff <= KIE_RST_BYTE;
            key_irq_ff <= 1'b0;
        end
        else if (i_ce)
        begin
            flags_ff   <= nxt_flags;
            pending_ff <= nxt_pending;
            key_irq_ff <= nxt_key_irq;
        end
    end

    assign o_key_irq = key_irq_ff;

    // ************************************************************
    // interrupt status and output
    // ************************************************************
    // rise of the key request is the event; the cpu side sees it as edge
    wire key_rise   = nxt_key_irq & ~key_irq_ff;
    wire status_w1c = wr_en & sel_status & wdata_lo[KIE_STAT_KEY_BIT];
    assign nxt_status = (status_ff & ~status_w1c) | key_rise;

    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
            status_ff <= 1'b0;
        else if (i_ce)
            status_ff <= nxt_status;
    end

    assign o_irq = status_ff & mask_ff;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_resetn || !i_ce);

    sequence s_clear_all;
        mode && wr_flags && flags_busy && (kept_flags == 8'h00) && (pending_ff != 8'h00);
    endsequence

    sequence s_gap_then_irq;
        !key_irq_ff ##1 key_irq_ff;
    endsequence

    AST_MODE0_LEVEL: assert property (
        (!$past(mode) && $past(i_ce)) |-> (key_irq_ff == $past(lvl_hit)))
        else $error("mode 0 request does not follow enabled pin level");

    AST_DISABLED_QUIET: assert property (
        (!mode && (en_ff == 8'h00)) [*3] |-> !key_irq_ff)
        else $error("request raised with all channels disabled");

    AST_FLAG_W1_NOP: assert property (
        (mode && wr_flags && (wdata_lo == 8'hff) && flags_busy)
        |=> (flags_ff == $past(flags_ff)))
        else $error("writing ones changed the event flags");

    AST_FLAG_CLEAR: assert property (
        (mode && wr_flags && flags_busy) |=> ((flags_ff & ~$past(wdata_lo)) == 8'h00))
        else $error("flag written zero was not cleared");

    AST_PEND_XFER: assert property (
        s_clear_all |=> s_gap_then_irq)
        else $error("held edge did not raise request one clock after clear");

    AST_FIRST_EDGE: assert property (
        (mode && !flags_busy && (pending_ff == 8'h00) && (ev_all != 8'h00))
        |=> (flags_ff == $past(ev_all)))
        else $error("edge on idle flags not captured");

    AST_IRQ_RAISE: assert property (
        (mode && (ev_all != 8'h00)) |-> ##[1:2] key_irq_ff)
        else $error("valid edge did not raise key request");

    AST_CTRL_ZERO: assert property (
        ((bus_st_ff == KIE_BUS_RDOUT) && sel_ctrl)
        |-> ((o_hrdata[31:8] == 24'h00_0000) && (o_hrdata[6:1] == 6'h00)
             && (o_hrdata[KIE_CTRL_MODE_BIT] == ctrl_ff.flag_mode_select)
             && (o_hrdata[KIE_CTRL_POL_BIT] == ctrl_ff.edge_polarity_select)))
        else $error("control register read back wrong");

    AST_ENABLE_WR: assert property (
        (wr_en && sel_enable) |=> (en_ff == $past(wdata_lo)))
        else $error("enable register write not stored");

    // a read holds the bus exactly one cycle while i_ce stays high; with i_ce low the wait lasts longer
    sequence s_read_wait;
        !o_hreadyout ##1 o_hreadyout;
    endsequence

    AST_READ_WAIT: assert property (
        (bus_st_ff == KIE_BUS_RDCAP) |-> s_read_wait)
        else $error("read wait state missing or held too long");

    AST_STATUS_SET: assert property (
        key_rise |=> status_ff)
        else $error("rise of key request did not set status");

    AST_STATUS_CLR: assert property (
        (status_w1c && !key_rise) |=> !status_ff)
        else $error("status bit not cleared by writing one");

    AST_MODE0_NOFLAG: assert property (
        !mode |=> ((flags_ff == 8'h00) && (pending_ff == 8'h00)))
        else $error("event flags kept while flag mode is off");

endmodule

//--- hw/kie_pkg.sv
/*
 * kie_pkg: constants, bus types and register map of the key input edge
 * interrupt block.
 * Assumes a 32-bit AHB-Lite bus with one word per register. The byte
 * address of each register is four times its index.
 */
package kie_pkg;

    // ************************************************************
    // channel count
    // ************************************************************
    localparam int          KIE_NCH            = 8;

    // ************************************************************
    // register indices and byte addresses
    // ************************************************************
    localparam logic [19:0] KIE_IDX_CTRL       = 20'hfff34;
    localparam logic [19:0] KIE_IDX_FLAGS      = 20'hfff35;
    localparam logic [19:0] KIE_IDX_ENABLE     = 20'hfff37;
    localparam logic [19:0] KIE_IDX_STATUS     = 20'hfff38;
    localparam logic [19:0] KIE_IDX_MASK       = 20'hfff39;

    localparam logic [31:0] KIE_ADDR_CTRL      = {10'h000, KIE_IDX_CTRL, 2'h0};
    localparam logic [31:0] KIE_ADDR_FLAGS     = {10'h000, KIE_IDX_FLAGS, 2'h0};
    localparam logic [31:0] KIE_ADDR_ENABLE    = {10'h000, KIE_IDX_ENABLE, 2'h0};
    localparam logic [31:0] KIE_ADDR_STATUS    = {10'h000, KIE_IDX_STATUS, 2'h0};
    localparam logic [31:0] KIE_ADDR_MASK      = {10'h000, KIE_IDX_MASK, 2'h0};

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int          KIE_CTRL_MODE_BIT  = 7;
    localparam int          KIE_CTRL_POL_BIT   = 0;
    localparam int          KIE_STAT_KEY_BIT   = 0;
    localparam int          KIE_HTRANS_ACT_BIT = 1;
    localparam logic [7:0]  KIE_RST_BYTE       = 8'h00;
    localparam logic [7:0]  KIE_ALL_ONES       = 8'hff;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        KIE_BUS_IDLE,
        KIE_BUS_WRITE,
        KIE_BUS_RDCAP,
        KIE_BUS_RDOUT
    } kie_bus_e;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
    } kie_ahb_req_s;

    typedef struct packed {
        logic flag_mode_select;
        logic edge_polarity_select;
    } kie_ctrl_s;

endpackage

//--- verif/kie_key_irq_tb_top.sv
/*
 * kie_key_irq_tb_top: self-checking bench of the key edge interrupt.
 * Assumes kie_key_model on the pins and a single AHB-Lite master here.
 */
`timescale 1ns/1ps
module kie_key_irq_tb_top
    import kie_pkg::*;
;
    logic         i_mclk;
    logic         i_resetn;
    logic [31:0]  haddr;
    logic [1:0]   htrans;
    logic         hwrite;
    logic [31:0]  hwdata;
    logic [31:0]  hrdata;
    logic         hready;
    logic         key_irq;
    logic         irq;
    logic         hresp;
    logic         ce;
    logic         rsp;
    logic [7:0]   drive;
    logic [7:0]   lvl;
    logic         slow;
    logic [7:0]   pins;
    logic [31:0]  rd;
    logic         irq_q;
    logic         pol;
    logic [7:0]   en;
    logic [7:0]   p;
    int           r0;
    int           rises;
    int           mismatches;
    int           checked;
    kie_ahb_req_s ahb;
    logic [31:0]  adr_list [6] = '{KIE_ADDR_CTRL, KIE_ADDR_FLAGS, KIE_ADDR_ENABLE,
                                   KIE_ADDR_STATUS, KIE_ADDR_MASK, 32'h003ffcd8};

    // ****************************************
    // design, switches, clock
    // ****************************************
    assign ahb = {1'b1, haddr, htrans, hwrite, 3'h2, hready};
    kie_key_irq kie_key_irq_i
    (
        .i_mclk           (i_mclk),
        .i_resetn         (i_resetn),
        .i_ce             (ce),
        .i_ahb            (ahb),
        .i_hwdata         (hwdata),
        .o_hrdata         (hrdata),
        .o_hreadyout      (hready),
        .o_hresp          (hresp),
        .i_key_input_pins (pins),
        .o_key_irq        (key_irq),
        .o_irq            (irq)
    );
    kie_key_model kie_key_model_i
    (
        .i_mclk  (i_mclk),
        .i_drive (drive),
        .i_lvl   (lvl),
        .i_slow  (slow),
        .o_pins  (pins)
    );
    always #5 i_mclk = ~i_mclk;

    // counts request rises, one expected per valid edge in flag mode
    always @(posedge i_mclk)
    begin
        irq_q <= key_irq;
        if (key_irq === 1'b1 && irq_q === 1'b0)
            rises <= rises + 1;
    end

    // ****************************************
    // tasks and expectations
    // ****************************************
    task automatic conclude();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
    endtask

    // hready and hrdata are settled by the falling edge before the sample
    task automatic wrdy(inout int n);
        logic r;
        do
        begin
            @(negedge i_mclk);
            r = hready;
            rd = hrdata;
            rsp = rsp | hresp;
            @(posedge i_mclk);
            n++;
        end
        while (r !== 1'b1 && n < 40);
    endtask

    task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
        int n;
        n = 0;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        wrdy(n);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wrdy(n);
        if (n >= 40)
        begin
            mismatches++;
            conclude();
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 8'h0);
        chk(rd, e);
    endtask

    task automatic press(input logic [7:0] d, input logic [7:0] v);
        drive <= d;
        lvl   <= v;
        cyc(8);
    endtask

    // level-mode request: any enabled pin at its active level
    function automatic logic lvl_irq(input logic [7:0] pn, input logic [7:0] e,
                                     input logic pl);
        return |(e & (pl ? pn : ~pn));
    endfunction

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        i_mclk = 1'b0;
        i_resetn = 1'b0;
        {haddr, htrans, hwrite, hwdata} = '0;
        {drive, lvl, slow, irq_q, rsp} = '0;
        ce = 1'b1;
        {rises, mismatches, checked} = '0;
        void'($urandom(83772));
        cyc(16);
        i_resetn <= 1'b1;
        cyc(1);
        // reset values, an unmapped word, reserved control bits
        foreach (adr_list[k]) rdchk(adr_list[k], 32'h0);
        wr(adr_list[5], 8'hff);
        rdchk(adr_list[5], 32'h0);
        wr(KIE_ADDR_CTRL, 8'hff);
        rdchk(KIE_ADDR_CTRL, 32'h81);
        wr(KIE_ADDR_ENABLE, 8'ha5);
        rdchk(KIE_ADDR_ENABLE, 32'ha5);
        wr(KIE_ADDR_CTRL, 8'h00);
        $display("test registers done");
        // level mode, falling edge, channels 0 and 1 only
        wr(KIE_ADDR_ENABLE, 8'h03);
        press(8'h10, 8'h00);
        chk(32'(key_irq), 32'h0);
        press(8'h11, 8'h00);
        chk(32'(key_irq), 32'h1);
        r0 = rises;
        press(8'h13, 8'h00);
        press(8'h12, 8'h00);
        chk(32'(key_irq), 32'h1);
        chk(rises, r0);
        press(8'h00, 8'h00);
        chk(32'(key_irq), 32'h0);
        $display("test level mode done");
        // clock enable low freezes the request even with a pin active
        ce <= 1'b0;
        press(8'h01, 8'h00);
        chk(32'(key_irq), 32'h0);
        ce <= 1'b1;
        cyc(8);
        chk(32'(key_irq), 32'h1);
        press(8'h00, 8'h00);
        $display("test clock enable done");
        // random pins, enables and polarity, prompt and slow switches
        repeat (30)
        begin
            pol = 1'($urandom);
            en = 8'($urandom);
            p = 8'($urandom);
            slow <= 1'($urandom);
            wr(KIE_ADDR_CTRL, {7'h0, pol});
            wr(KIE_ADDR_ENABLE, en);
            press(8'hff, p);
            chk(32'(key_irq), 32'(lvl_irq(p, en, pol)));
        end
        slow <= 1'b0;
        wr(KIE_ADDR_CTRL, 8'h00);
        wr(KIE_ADDR_ENABLE, 8'h00);
        press(8'h04, 8'h00);
        $display("test random done");
        // enable onto an active pin, hidden behind the mask
        wr(KIE_ADDR_MASK, 8'h00);
        wr(KIE_ADDR_ENABLE, 8'h04);
        cyc(8);
        chk(32'(key_irq), 32'h1);
        wr(KIE_ADDR_STATUS, 8'h01);
        wr(KIE_ADDR_MASK, 8'h01);
        cyc(1);
        chk(32'(irq), 32'h0);
        press(8'h00, 8'h00);
        $display("test enable active done");
        // flag mode: one request per edge, later edge waits for the clear
        wr(KIE_ADDR_CTRL, 8'h80);
        wr(KIE_ADDR_ENABLE, 8'h03);
        wr(KIE_ADDR_STATUS, 8'h01);
        r0 = rises;
        press(8'h01, 8'h00);
        rdchk(KIE_ADDR_FLAGS, 32'h01);
        chk(32'(irq), 32'h1);
        press(8'h03, 8'h00);
        rdchk(KIE_ADDR_FLAGS, 32'h01);
        wr(KIE_ADDR_FLAGS, 8'hff);
        rdchk(KIE_ADDR_FLAGS, 32'h01);
        press(8'h02, 8'h00);
        wr(KIE_ADDR_FLAGS, 8'hfe);
        @(negedge i_mclk);
        chk(32'(key_irq), 32'h0);
        @(negedge i_mclk);
        chk(32'(key_irq), 32'h1);
        @(posedge i_mclk);
        rdchk(KIE_ADDR_FLAGS, 32'h02);
        wr(KIE_ADDR_FLAGS, 8'hfd);
        cyc(8);
        chk(32'(key_irq), 32'h0);
        chk(rises, r0 + 2);
        rdchk(KIE_ADDR_STATUS, 32'h01);
        wr(KIE_ADDR_MASK, 8'h00);
        cyc(1);
        chk(32'(irq), 32'h0);
        wr(KIE_ADDR_STATUS, 8'h01);
        rdchk(KIE_ADDR_STATUS, 32'h00);
        press(8'h00, 8'h00);
        $display("test flag mode done");
        chk(32'(rsp), 32'h0);
        conclude();
    end
endmodule

//--- verif/kie_key_model.sv
/*
 * kie_key_model: eight key switches on the key pins, pulled up when open.
 * Assumes the bench changes its requests right after a rising edge.
 */
`timescale 1ns/1ps
module kie_key_model
(
    input  wire logic       i_mclk,   // block clock
    input  wire logic [7:0] i_drive,  // 1 closes the switch
    input  wire logic [7:0] i_lvl,    // level of a closed switch
    input  wire logic       i_slow,   // 1 adds one clock of delay
    output logic      [7:0] o_pins    // key pins
);
    logic [7:0] d1_ff;
    logic [7:0] d2_ff;

    // ****************************************
    // switch delay line
    // ****************************************
    // an open pin goes to the pull-up, never keeps its last level
    always @(posedge i_mclk)
    begin
        d1_ff <= (i_drive & i_lvl) | ~i_drive;
        d2_ff <= d1_ff;
    end

    // pins move 3 ns after the edge, so never on a sampling instant
    always @(posedge i_mclk)
    begin
        #3 o_pins = i_slow ? d2_ff : d1_ff;
    end
endmodule
